// file: hdl/msqf_framer.sv
`timescale 1ns/10ps

// Behaviour
// - read request is kind 0x05 with fields
// - multi-byte fields travel low byte first
// - read answered by kind 0x85 reply
// - reply tag equals request tag
// - reply echoes fifteen request bytes, then value
// - link quality byte follows value bytes
// - length byte counts everything after it
// - channel two value: cluster 1, offset 4
// - discovery request is kind 0x64
// - discovery request length is six
// - discovery ends with timeout byte, 0-60 s
// - own-address reply only on matching profile and endpoint
// - discovery reply kind 0xe4, length 4
// - discovery reply tag equals request tag
// - discovery reply carries network address
// - timeout emits kind 0x65 with count
module msqf_framer #(
  parameter int SECOND_CYCLES = msqf_pkg::SECOND_CYCLES
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire msqf_pkg::msqf_byte_type rx_byte,
  output msqf_pkg::msqf_byte_type      tx_byte,
  input  wire logic                    tx_ready,
  input  wire logic [15:0]             own_profile,
  input  wire logic [7:0]              own_endpoint,
  input  wire logic [15:0]             own_nwk_address,
  output msqf_pkg::msqf_get_type       get_request,
  output logic                         get_request_valid,
  input  wire logic                    get_value_valid,
  input  wire logic [7:0]              get_value_byte,
  output logic                         get_value_ready,
  input  wire logic [7:0]              link_quality,
  input  wire logic                    disc_reply_valid,
  input  wire logic [15:0]             disc_reply_address,
  output logic                         disc_reply_ready,
  output logic                         disc_busy,
  output logic                         frame_error
);

  typedef enum {
    HUNT, LEN, BODY, DECODE, SEND, VALUE, DISC_WAIT
  } msqf_state_type;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  msqf_state_type state_q;
  msqf_state_type state_d;
  logic [7:0]     buf_q [msqf_pkg::BUF_DEPTH];
  logic [7:0]     buf_d [msqf_pkg::BUF_DEPTH];
  logic [7:0]     len_q;
  logic [7:0]     len_d;
  logic [7:0]     idx_q;
  logic [7:0]     idx_d;
  logic [7:0]     tx_cnt_q;
  logic [7:0]     tx_cnt_d;
  logic [7:0]     tx_len_q;
  logic [7:0]     tx_len_d;
  logic [7:0]     tx_kind_q;
  logic [7:0]     tx_kind_d;
  logic [7:0]     val_left_q;
  logic [7:0]     val_left_d;
  logic [7:0]     disc_tag_q;
  logic [7:0]     disc_tag_d;
  logic [15:0]    reply_cnt_q;
  logic [15:0]    reply_cnt_d;
  logic [15:0]    disc_addr_q;
  logic [15:0]    disc_addr_d;
  logic           disc_q;
  logic           disc_d;
  logic           end_pend_q;
  logic           end_pend_d;
  logic           err_q;
  logic           err_d;

  msqf_pkg::msqf_byte_type stage_byte;
  logic                    stage_ready;
  logic                    timer_start;
  logic [7:0]              timer_secs;
  logic                    timer_expired;
  logic [7:0]              send_byte;

  // ---------------------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------------------
  msqf_byte_tx u_tx (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_byte   (stage_byte),
    .in_ready  (stage_ready),
    .out_byte  (tx_byte),
    .out_ready (tx_ready)
  );

  msqf_sec_timer #(.SECOND_CYCLES(SECOND_CYCLES)) u_timer (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (timer_start),
    .seconds (timer_secs),
    .expired (timer_expired)
  );

  // ---------------------------------------------------------------------------
  // request view
  // ---------------------------------------------------------------------------
  always_comb begin
    get_request.tag      = buf_q[msqf_pkg::POS_TAG];
    get_request.profile  = {buf_q[msqf_pkg::POS_PROF + 1], buf_q[msqf_pkg::POS_PROF]};
    get_request.endpoint = buf_q[msqf_pkg::POS_EP];
    get_request.cluster  = buf_q[msqf_pkg::POS_CLUSTER];
    get_request.offset   = {buf_q[msqf_pkg::POS_OFFSET + 1], buf_q[msqf_pkg::POS_OFFSET]};
    get_request.length   = buf_q[msqf_pkg::POS_LEN];
  end

  assign get_request_valid = (state_q == VALUE);
  assign disc_busy         = disc_q;
  assign frame_error       = err_q;
  assign timer_secs        = (buf_q[msqf_pkg::DISC_POS_TO] > msqf_pkg::TIMEOUT_MAX)
                             ? msqf_pkg::TIMEOUT_MAX : buf_q[msqf_pkg::DISC_POS_TO];

  // ---------------------------------------------------------------------------
  // outgoing byte select: start, length, tag, kind, then arguments
  // ---------------------------------------------------------------------------
  always_comb begin
    send_byte = 8'h00;
    if (tx_cnt_q == 8'd0) begin
      send_byte = msqf_pkg::START_BYTE;
    end else if (tx_cnt_q == 8'd1) begin
      send_byte = tx_len_q;
    end else if (tx_cnt_q == 8'd2) begin
      if (tx_kind_q == msqf_pkg::KIND_GET_REPLY) begin
        send_byte = buf_q[msqf_pkg::POS_TAG];
      end else begin
        send_byte = disc_tag_q;
      end
    end else if (tx_cnt_q == 8'd3) begin
      send_byte = tx_kind_q;
    end else if (tx_kind_q == msqf_pkg::KIND_GET_REPLY) begin
      send_byte = buf_q[5'(tx_cnt_q - 8'd2)];
    end else if (tx_kind_q == msqf_pkg::KIND_DISC_REPLY) begin
      send_byte = (tx_cnt_q == 8'd4) ? disc_addr_q[7:0] : disc_addr_q[15:8];
    end else begin
      send_byte = (tx_cnt_q == 8'd4) ? reply_cnt_q[7:0] : reply_cnt_q[15:8];
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    buf_d       = buf_q;
    len_d       = len_q;
    idx_d       = idx_q;
    tx_cnt_d    = tx_cnt_q;
    tx_len_d    = tx_len_q;
    tx_kind_d   = tx_kind_q;
    val_left_d  = val_left_q;
    disc_tag_d  = disc_tag_q;
    reply_cnt_d = reply_cnt_q;
    disc_addr_d = disc_addr_q;
    disc_d      = disc_q;
    end_pend_d  = end_pend_q || timer_expired;
    err_d       = 1'b0;
    stage_byte  = '0;
    timer_start = 1'b0;
    get_value_ready  = 1'b0;
    disc_reply_ready = 1'b0;
    case (state_q)
      HUNT: begin
        if (rx_byte.valid && rx_byte.data == msqf_pkg::START_BYTE) begin
          state_d = LEN;
        end else if (disc_q && end_pend_q) begin
          tx_kind_d  = msqf_pkg::KIND_DISC_END;
          tx_len_d   = msqf_pkg::DISC_END_LEN;
          tx_cnt_d   = 8'd0;
          end_pend_d = 1'b0;
          disc_d     = 1'b0;
          state_d    = SEND;
        end else if (disc_q && disc_reply_valid) begin
          disc_reply_ready = 1'b1;
          disc_addr_d = disc_reply_address;
          reply_cnt_d = reply_cnt_q + 16'h0001;
          tx_kind_d   = msqf_pkg::KIND_DISC_REPLY;
          tx_len_d    = msqf_pkg::DISC_REPLY_LEN;
          tx_cnt_d    = 8'd0;
          state_d     = SEND;
        end
      end
      LEN: begin
        if (rx_byte.valid) begin
          len_d = rx_byte.data;
          idx_d = 8'd0;
          if (rx_byte.data == 8'h00 || rx_byte.data > 8'(msqf_pkg::BUF_DEPTH)) begin
            err_d   = 1'b1;
            state_d = HUNT;
          end else begin
            state_d = BODY;
          end
        end
      end
      BODY: begin
        if (rx_byte.valid) begin
          buf_d[5'(idx_q)] = rx_byte.data;
          idx_d = idx_q + 8'd1;
          if (idx_q + 8'd1 == len_q) begin
            state_d = DECODE;
          end
        end
      end
      DECODE: begin
        state_d = HUNT;
        if (buf_q[msqf_pkg::POS_KIND] == msqf_pkg::KIND_GET
            && len_q == msqf_pkg::GET_HDR_LEN
            && buf_q[msqf_pkg::POS_LEN] <= 8'(msqf_pkg::BUF_DEPTH)) begin
          tx_kind_d  = msqf_pkg::KIND_GET_REPLY;
          tx_len_d   = len_q + buf_q[msqf_pkg::POS_LEN] + 8'd1;
          tx_cnt_d   = 8'd0;
          val_left_d = buf_q[msqf_pkg::POS_LEN];
          state_d    = SEND;
        end else if (buf_q[msqf_pkg::POS_KIND] == msqf_pkg::KIND_DISC
                     && len_q == msqf_pkg::DISC_LEN && !disc_q) begin
          if ({buf_q[msqf_pkg::POS_ARG + 1], buf_q[msqf_pkg::POS_ARG]} == own_profile
              && buf_q[msqf_pkg::POS_ARG + 2] == own_endpoint) begin
            disc_tag_d  = buf_q[msqf_pkg::POS_TAG];
            reply_cnt_d = 16'h0001;
            disc_addr_d = own_nwk_address;
            tx_kind_d   = msqf_pkg::KIND_DISC_REPLY;
            tx_len_d    = msqf_pkg::DISC_REPLY_LEN;
            tx_cnt_d    = 8'd0;
            state_d     = SEND;
          end else begin
            disc_tag_d  = buf_q[msqf_pkg::POS_TAG];
            reply_cnt_d = 16'h0000;
          end
          disc_d      = 1'b1;
          end_pend_d  = 1'b0;
          timer_start = 1'b1;
        end else begin
          err_d = 1'b1;
        end
      end
      SEND: begin
        stage_byte.valid = 1'b1;
        stage_byte.data  = send_byte;
        if (stage_ready) begin
          tx_cnt_d = tx_cnt_q + 8'd1;
          if (tx_kind_q == msqf_pkg::KIND_GET_REPLY
              && tx_cnt_q == 8'(msqf_pkg::ECHO_BYTES + 3)) begin
            state_d = (val_left_q == 8'd0) ? DISC_WAIT : VALUE;
          end else if (tx_kind_q != msqf_pkg::KIND_GET_REPLY && tx_cnt_q == 8'd5) begin
            state_d = HUNT;
          end
        end
      end
      VALUE: begin
        stage_byte.valid = get_value_valid;
        stage_byte.data  = get_value_byte;
        get_value_ready  = stage_ready;
        if (get_value_valid && stage_ready) begin
          val_left_d = val_left_q - 8'd1;
          if (val_left_q == 8'd1) begin
            state_d = DISC_WAIT;
          end
        end
      end
      DISC_WAIT: begin
        stage_byte.valid = 1'b1;
        stage_byte.data  = link_quality;
        if (stage_ready) begin
          state_d = HUNT;
        end
      end
      default: begin
        state_d = HUNT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q     <= HUNT;
      buf_q       <= '{default: 8'h00};
      len_q       <= 8'h00;
      idx_q       <= 8'h00;
      tx_cnt_q    <= 8'h00;
      tx_len_q    <= 8'h00;
      tx_kind_q   <= 8'h00;
      val_left_q  <= 8'h00;
      disc_tag_q  <= 8'h00;
      reply_cnt_q <= 16'h0000;
      disc_addr_q <= 16'h0000;
      disc_q      <= 1'b0;
      end_pend_q  <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      state_q     <= state_d;
      buf_q       <= buf_d;
      len_q       <= len_d;
      idx_q       <= idx_d;
      tx_cnt_q    <= tx_cnt_d;
      tx_len_q    <= tx_len_d;
      tx_kind_q   <= tx_kind_d;
      val_left_q  <= val_left_d;
      disc_tag_q  <= disc_tag_d;
      reply_cnt_q <= reply_cnt_d;
      disc_addr_q <= disc_addr_d;
      disc_q      <= disc_d;
      end_pend_q  <= end_pend_d;
      err_q       <= err_d;
    end
  end

endmodule // msqf_framer

// file: hdl/msqf_pkg.sv
package msqf_pkg;

  // ---------------------------------------------------------------------------
  // framing constants
  // ---------------------------------------------------------------------------
  localparam logic [7:0] START_BYTE      = 8'hfd;
  localparam logic [7:0] KIND_GET        = 8'h05;
  localparam logic [7:0] KIND_GET_REPLY  = 8'h85;
  localparam logic [7:0] KIND_DISC       = 8'h64;
  localparam logic [7:0] KIND_DISC_REPLY = 8'he4;
  localparam logic [7:0] KIND_DISC_END   = 8'h65;
  localparam logic [7:0] DISC_LEN        = 8'h06;
  localparam logic [7:0] DISC_REPLY_LEN  = 8'h04;
  localparam logic [7:0] DISC_END_LEN    = 8'h04;
  localparam logic [7:0] GET_HDR_LEN     = 8'h11;
  localparam logic [7:0] TIMEOUT_MAX     = 8'h3c;
  localparam logic [7:0] NWK_ADDR_MARK   = 8'h80;
  localparam logic [7:0] ADC_CLUSTER     = 8'h01;
  localparam logic [15:0] ADC_OFFSET     = 16'h0004;
  localparam logic [7:0] ADC_LENGTH      = 8'h02;

  // ---------------------------------------------------------------------------
  // field positions in the collected frame (index after the length byte)
  // ---------------------------------------------------------------------------
  localparam int POS_TAG     = 0;
  localparam int POS_KIND    = 1;
  localparam int POS_ARG     = 2;
  localparam int POS_PROF    = 10;
  localparam int POS_EP      = 12;
  localparam int POS_CLUSTER = 13;
  localparam int POS_OFFSET  = 14;
  localparam int POS_LEN     = 16;
  localparam int DISC_POS_TO = 5;
  localparam int ECHO_BYTES  = 15;
  localparam int BUF_DEPTH   = 32;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ         = 40_000_000;
  localparam int SECOND_CYCLES  = CLK_HZ;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } msqf_byte_type;

  typedef struct packed {
    logic [7:0]  tag;
    logic [15:0] profile;
    logic [7:0]  endpoint;
    logic [7:0]  cluster;
    logic [15:0] offset;
    logic [7:0]  length;
  } msqf_get_type;

endpackage

// file: hdl/msqf_byte_tx.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// one-byte output stage with handshake
// ---------------------------------------------------------------------------
module msqf_byte_tx (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire msqf_pkg::msqf_byte_type in_byte,
  output logic                        in_ready,
  output msqf_pkg::msqf_byte_type     out_byte,
  input  wire logic                   out_ready
);

  msqf_pkg::msqf_byte_type hold_q;
  msqf_pkg::msqf_byte_type hold_d;

  assign in_ready = !hold_q.valid || out_ready;
  assign out_byte = hold_q;

  always_comb begin
    hold_d = hold_q;
    if (hold_q.valid && out_ready) begin
      hold_d.valid = 1'b0;
    end
    if (in_byte.valid && in_ready) begin
      hold_d = in_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_q <= '0;
    end else begin
      hold_q <= hold_d;
    end
  end

endmodule // msqf_byte_tx

// file: hdl/msqf_sec_timer.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------------------
// whole-second countdown
// ---------------------------------------------------------------------------
module msqf_sec_timer #(
  parameter int SECOND_CYCLES = msqf_pkg::SECOND_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] seconds,
  output logic            expired
);

  logic [31:0] tick_q;
  logic [31:0] tick_d;
  logic [7:0]  secs_q;
  logic [7:0]  secs_d;
  logic        run_q;
  logic        run_d;
  logic        exp_q;
  logic        exp_d;

  assign expired = exp_q;

  always_comb begin
    tick_d = tick_q;
    secs_d = secs_q;
    run_d  = run_q;
    exp_d  = 1'b0;
    if (start) begin
      run_d  = 1'b1;
      secs_d = seconds;
      tick_d = 32'h0;
    end else if (run_q) begin
      if (secs_q == 8'h00) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else if (tick_q == 32'(SECOND_CYCLES - 1)) begin
        tick_d = 32'h0;
        secs_d = secs_q - 8'h01;
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_q <= 32'h0;
      secs_q <= 8'h00;
      run_q  <= 1'b0;
      exp_q  <= 1'b0;
    end else begin
      tick_q <= tick_d;
      secs_q <= secs_d;
      run_q  <= run_d;
      exp_q  <= exp_d;
    end
  end

endmodule // msqf_sec_timer

// file: bench/msqf_framer_asserts.sv
`timescale 1ns/10ps

module msqf_framer_asserts #(
  parameter int SECOND_CYCLES = msqf_pkg::SECOND_CYCLES
) (
  input wire logic                    ref_clk,
  input wire logic                    reset,
  input wire msqf_pkg::msqf_byte_type tx_byte,
  input wire logic                    tx_ready,
  input wire msqf_pkg::msqf_get_type  get_request,
  input wire logic                    get_request_valid,
  input wire logic                    get_value_ready,
  input wire logic                    disc_reply_ready,
  input wire logic                    disc_busy,
  input wire logic                    frame_error
);
  // ----
  // position of each sent byte in its frame
  // ----
  logic [5:0] pos_q, pos_d;
  logic [7:0] len_q, len_d, tag_q, tag_d, kind_q, kind_d;

  always_comb begin
    pos_d  = pos_q;
    len_d  = len_q;
    tag_d  = tag_q;
    kind_d = kind_q;
    if (tx_byte.valid && tx_ready) begin
      pos_d = pos_q + 6'h01;
      if (pos_q == 6'h01) len_d = tx_byte.data;
      if (pos_q == 6'h02) tag_d = tx_byte.data;
      if (pos_q == 6'h03) kind_d = tx_byte.data;
      if (pos_q > 6'h01 && {2'h0, pos_q} == len_q + 8'h01) pos_d = 6'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pos_q  <= 6'h00;
      len_q  <= 8'h00;
      tag_q  <= 8'h00;
      kind_q <= 8'h00;
    end else begin
      pos_q  <= pos_d;
      len_q  <= len_d;
      tag_q  <= tag_d;
      kind_q <= kind_d;
    end
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence take_s;
    tx_byte.valid && tx_ready;
  endsequence

  sequence stall_s;
    tx_byte.valid && !tx_ready;
  endsequence

  reset_idle_a: assert property (disable iff (1'b0) reset |=>
    !tx_byte.valid && !disc_busy && !frame_error && !get_request_valid)
    else $error("outputs not idle after reset");
  tx_hold_a: assert property (stall_s |=> $stable(tx_byte))
    else $error("sent byte changed while stalled");
  start_byte_a: assert property (take_s ##0 pos_q == 6'h00 |->
    tx_byte.data == msqf_pkg::START_BYTE) else $error("frame without start byte");
  kind_legal_a: assert property (take_s ##0 pos_q == 6'h03 |->
    tx_byte.data inside {8'h85, 8'he4, 8'h65}) else $error("bad reply kind");
  disc_len_a: assert property (take_s ##0 (pos_q == 6'h03 &&
    tx_byte.data inside {8'he4, 8'h65}) |-> len_q == 8'h04) else $error("bad discovery length");
  get_len_a: assert property (take_s ##0 (pos_q == 6'h12 && kind_q == 8'h85) |->
    len_q == tx_byte.data + 8'h12) else $error("bad read reply length");
  tag_echo_a: assert property (get_request_valid && kind_q == 8'h85 |->
    get_request.tag == tag_q) else $error("reply tag differs");
  value_ready_a: assert property (get_value_ready |-> get_request_valid)
    else $error("value taken outside read");
  disc_ready_a: assert property (disc_reply_ready |-> disc_busy)
    else $error("remote reply taken outside discovery");
  err_pulse_a: assert property ($rose(frame_error) |=> !frame_error)
    else $error("frame error longer than one cycle");
endmodule // msqf_framer_asserts

bind msqf_framer msqf_framer_asserts #(.SECOND_CYCLES(SECOND_CYCLES)) chk_u (
  .ref_clk(ref_clk), .reset(reset), .tx_byte(tx_byte), .tx_ready(tx_ready),
  .get_request(get_request), .get_request_valid(get_request_valid),
  .get_value_ready(get_value_ready), .disc_reply_ready(disc_reply_ready),
  .disc_busy(disc_busy), .frame_error(frame_error));

// file: bench/msqf_host_model.sv
`timescale 1ns/10ps

module msqf_host_model (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  output msqf_pkg::msqf_byte_type      rx_byte,
  input  wire msqf_pkg::msqf_byte_type tx_byte,
  output logic                         tx_ready,
  input  wire logic                    slow
);
  logic [7:0] to_dev [$];
  logic [7:0] got [$];
  logic [1:0] cnt = 2'h0;

  initial begin
    rx_byte  = '0;
    tx_ready = 1'b0;
  end

  // one byte a cycle; idle data line shows a changing pattern
  always @(negedge ref_clk) begin
    cnt      <= cnt + 2'h1;
    tx_ready <= !reset && (!slow || cnt == 2'h3);
    if (!reset && to_dev.size() > 0) rx_byte <= {1'b1, to_dev.pop_front()};
    else rx_byte <= {1'b0, ~rx_byte.data};
  end

  always @(posedge ref_clk) begin
    if (!reset && tx_byte.valid && tx_ready) got.push_back(tx_byte.data);
  end
endmodule // msqf_host_model

// file: bench/tb_msqf_framer.sv
`timescale 1ns/10ps

module tb_msqf_framer;
  localparam int SEC = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  msqf_pkg::msqf_byte_type rx_byte, tx_byte;
  msqf_pkg::msqf_get_type  get_request;
  logic tx_ready, get_request_valid, get_value_valid, get_value_ready, disc_reply_valid;
  logic disc_reply_ready, disc_busy, frame_error, slow;
  logic [15:0] own_profile, own_nwk_address, disc_reply_address;
  logic [7:0] own_endpoint, get_value_byte, link_quality;
  logic [7:0] vals [0:7];
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'hfc32f1c7;
  int error_cnt = 0;
  int n_tests = 0;
  int err_seen = 0;
  int vi = 0;

  always #12.5 ref_clk = ~ref_clk;

  msqf_framer #(.SECOND_CYCLES(SEC)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .rx_byte(rx_byte), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .own_profile(own_profile), .own_endpoint(own_endpoint),
    .own_nwk_address(own_nwk_address), .get_request(get_request),
    .get_request_valid(get_request_valid), .get_value_valid(get_value_valid),
    .get_value_byte(get_value_byte), .get_value_ready(get_value_ready),
    .link_quality(link_quality), .disc_reply_valid(disc_reply_valid),
    .disc_reply_address(disc_reply_address), .disc_reply_ready(disc_reply_ready),
    .disc_busy(disc_busy), .frame_error(frame_error));

  msqf_host_model host_u (.ref_clk(ref_clk), .reset(reset), .rx_byte(rx_byte),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .slow(slow));

  always @(posedge ref_clk) begin
    if (frame_error === 1'b1) err_seen++;
    if (get_value_valid && get_value_ready === 1'b1) vi++;
  end

  // value source stalls at random to exercise the value handshake
  always @(negedge ref_clk) begin
    get_value_byte  <= vals[vi[2:0]];
    get_value_valid <= (rnd() > 8'h40);
  end

  // ----
  // helpers
  // ----
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task results();
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a wait that ran out of its bound
  task give_up();
    error_cnt++;
    results();
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // leading junk byte also covers the framer's return to idle
  task send(input logic [7:0] b [$]);
    host_u.to_dev.push_back(8'h00);
    foreach (b[i]) host_u.to_dev.push_back(b[i]);
  endtask

  task expect_frame();
    int t;
    for (t = 0; t < 3000 && host_u.got.size() < exp_q.size(); t++) @(posedge ref_clk);
    if (host_u.got.size() < exp_q.size()) begin
      error_cnt++;
      results();
    end
    foreach (exp_q[i]) check(host_u.got[i], exp_q[i]);
    host_u.got = {};
  endtask

  // ----
  // scenarios
  // ----
  task run_get(input logic [7:0] n, input logic [7:0] cl, input logic [15:0] off);
    logic [7:0] req [$];
    logic [7:0] tag;
    tag = rnd();
    vi = 0;
    foreach (vals[i]) vals[i] = rnd();
    @(negedge ref_clk);
    link_quality = rnd();
    req = {8'hfd, 8'h11, tag, msqf_pkg::KIND_GET, rnd(), rnd(), 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, msqf_pkg::NWK_ADDR_MARK, own_profile[7:0], own_profile[15:8], own_endpoint,
      cl, off[7:0], off[15:8], n};
    send(req);
    exp_q = {8'hfd, 8'h12 + n, tag, msqf_pkg::KIND_GET_REPLY};
    for (int i = 4; i < 19; i++) exp_q.push_back(req[i]);
    for (int i = 0; i < n; i++) exp_q.push_back(vals[i]);
    exp_q.push_back(link_quality);
    expect_frame();
    check(get_request.offset[15:8], off[15:8]);
    check(get_request.profile[15:8], own_profile[15:8]);
    check(get_request.cluster, cl);
    check(get_request.length, n);
  endtask

  task run_disc(input int mode, input logic [7:0] tmo, input int nrem);
    logic [7:0] req [$];
    logic [7:0] tag;
    logic [15:0] a;
    int cnt, t;
    tag = rnd();
    cnt = 0;
    req = {8'hfd, msqf_pkg::DISC_LEN, tag, msqf_pkg::KIND_DISC,
      own_profile[7:0] ^ (mode == 2 ? 8'h01 : 8'h00), own_profile[15:8],
      own_endpoint + (mode == 1 ? 8'h01 : 8'h00), tmo};
    send(req);
    if (mode == 0) begin
      exp_q = {8'hfd, 8'h04, tag, 8'he4, own_nwk_address[7:0], own_nwk_address[15:8]};
      expect_frame();
      cnt = 1;
    end
    repeat (nrem) begin
      a = {rnd(), rnd()};
      @(negedge ref_clk);
      disc_reply_valid = 1'b1;
      disc_reply_address = a;
      for (t = 0; t < 200; t++) begin
        @(posedge ref_clk);
        if (disc_reply_ready === 1'b1) break;
      end
      if (t == 200) give_up();
      @(negedge ref_clk);
      disc_reply_valid = 1'b0;
      exp_q = {8'hfd, 8'h04, tag, 8'he4, a[7:0], a[15:8]};
      expect_frame();
      cnt++;
    end
    for (t = 0; t < 3000 && disc_busy !== 1'b0; t++) @(negedge ref_clk);
    if (disc_busy !== 1'b0) give_up();
    exp_q = {8'hfd, 8'h04, tag, 8'h65, cnt[7:0], 8'h00};
    expect_frame();
  endtask

  task run_bad(input logic [7:0] b [$]);
    int e, t;
    e = err_seen;
    send(b);
    for (t = 0; t < 60 && err_seen == e; t++) @(negedge ref_clk);
    if (err_seen == e) give_up();
    check(8'(err_seen - e), 8'h01);
    check(8'(host_u.got.size()), 8'h00);
  endtask

  initial begin
    logic [7:0] bq [$];
    disc_reply_valid = 1'b0;
    disc_reply_address = 16'h0000;
    slow = 1'b0;
    link_quality = 8'h00;
    foreach (vals[i]) vals[i] = 8'h00;
    own_profile = {rnd(), rnd()};
    own_endpoint = rnd();
    own_nwk_address = {rnd(), rnd()};
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    for (int i = 0; i < 6; i++) begin
      slow = i[0];
      if (i == 0) run_get(msqf_pkg::ADC_LENGTH, msqf_pkg::ADC_CLUSTER, msqf_pkg::ADC_OFFSET);
      else run_get(i == 1 ? 8'h00 : (rnd() & 8'h07), rnd(), {rnd(), rnd()});
    end
    run_disc(0, 8'h08, 2);
    slow = 1'b1;
    run_disc(1, 8'h00, 0);
    run_disc(2, msqf_pkg::TIMEOUT_MAX, 0);
    bq = {8'hfd, 8'h00};
    run_bad(bq);
    bq = {8'hfd, 8'h21};
    run_bad(bq);
    bq = {8'hfd, 8'h05, 8'h01, 8'h64, 8'h00, 8'h00, 8'h01};
    run_bad(bq);
    bq = {8'hfd, 8'h02, 8'h01, 8'h33};
    run_bad(bq);
    results();
  end
endmodule // tb_msqf_framer
